// >>> logic/ssg_consts.svh
// constants for the ship switch mode and fault guard
`ifndef SSG_CONSTS_SVH
`define SSG_CONSTS_SVH
// clock rate in MHz, 250 MHz
`define SSG_CLK_MHZ 16'h00FA
// times in microseconds
`define SSG_T_SM_DLY_US 32'h0098_9680
`define SSG_T_WAKE_LONG_US 32'h000F_4240
`define SSG_T_WAKE_SHORT_US 32'h0000_3A98
`define SSG_T_RST_US 32'h0098_9680
`define SSG_T_RST_EXTERNAL_SHIP_SWITCH_US 32'h0005_5730
`define SSG_T_WEAK_RETRY_US 32'h1908_B100
`define SSG_T_UV_OFF_US 32'h0007_A120
`define SSG_T_INT_US 32'h0000_0100
// register byte addresses
`define SSG_ADR_CTRL 8'h00
`define SSG_ADR_MASK 8'h04
`define SSG_ADR_STAT 8'h08
`define SSG_ADR_FLAG 8'h0C
`define SSG_ADR_OUT 8'h10
// control register fields
`define SSG_C_MODE 1:0
`define SSG_C_DLY 2
`define SSG_C_WAKE 3
`define SSG_C_FIT 4
`define SSG_C_BOC 5
`define SSG_C_IOC 6
`define SSG_C_HIZ 7
`define SSG_C_DIS 8
`define SSG_C_RRST 9
`define SSG_C_RS 10
`define SSG_CTRL_W 11
`define SSG_CTRL_RST 11'h000
// event indices
`define SSG_NEV 11
`define SSG_E_VAC1 0
`define SSG_E_VAC2 1
`define SSG_E_BOVP 2
`define SSG_E_WEAK 3
`define SSG_E_SOVP 4
`define SSG_E_SSHT 5
`define SSG_E_BATOVP 6
`define SSG_E_BOCP 7
`define SSG_E_IOCP 8
`define SSG_E_RSOVP 9
`define SSG_E_RSUV 10
`define SSG_MASK_RST 11'h000
`endif

// >>> logic/ssg_pkg.sv
// types for the ship switch mode and fault guard
package ssg_pkg;
   typedef enum logic [1:0] {
      CTL_IDLE = 2'b00,
      CTL_SHUT = 2'b01,
      CTL_SHIP = 2'b10,
      CTL_PRST = 2'b11
   } ssg_ctl_e;
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_ARM = 3'b001,
      M_SHIP = 3'b010,
      M_SHUT = 3'b011,
      M_PRST = 3'b100
   } ssg_mode_e;
   // digitized comparator outputs, all active high
   typedef struct packed {
      logic adapter_present;
      logic bus_high;
      logic vac1_ovp;
      logic vac2_ovp;
      logic bus_ovp;
      logic weak_fail;
      logic sys_ovp;
      logic sys_short;
      logic bat_above_104;
      logic bat_above_102;
      logic bat_ocp;
      logic in_ocp;
      logic rs_ovp_rise;
      logic rs_ovp_fall;
      logic rs_uv;
   } ssg_cmp_s;
   // switch gates and converter controls
   typedef struct packed {
      logic ext_ship_on;
      logic batt_sw_on;
      logic in_sw1_on;
      logic in_sw2_on;
      logic in_sel;
      logic conv_en;
      logic cur_limit;
      logic sys_sink;
      logic input_hiz;
      logic slow_clk;
      logic serial_off;
   } ssg_drv_s;
endpackage

// >>> logic/ssg_top.sv
// ship switch mode control and protection fault guard
// How it works
// - writing 01 without input voltage enters shutdown; only adapter attach wakes
// - ship switch opens at once or after 10 s, per delay select
// - a 01 write while bus voltage is high leaves the field at 00
// - leaving shutdown returns the mode field to 00
// - writing 10 enters ship mode: both switches off, slow clock, bus alive
// - a 10 write while bus voltage is high leaves the field at 00
// - ship exits on adapter, write 00, register reset or button hold
// - ship exit closes both switches and sets the field to 00
// - writing 11 or a 10 s button hold starts a power reset
// - power reset opens ship switch 350 ms, input high impedance if bus high
// - while ship switch is open in power reset, system sink is on
// - adapter overvoltage opens that input switch and selects the other input
// - bus overvoltage stops converter, battery switch feeds system, reports
// - weak source stops switching, reports, retests every 7 minutes
// - system overvoltage stops switching until rail recovers, reports
// - system short limits converter current below 1 A, reports
// - battery overvoltage stops converter above 104%, restarts below 102%
// - battery overcurrent opens ship switch only if fitted and enabled
// - enabled input overcurrent sets hiz request and input switch disable
// - input overcurrent is always reported, acted on only when enabled
// - reverse source overvoltage stops at next switching cycle, hysteresis
// - reverse source undervoltage shuts converter 500 ms then retries
// - each unmasked event gives a 256 us low notification pulse
// - flags latch on status rising edge and clear on read
// - finished power reset returns the field to 00
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ssg_consts.svh"
module ssg_top
   import ssg_pkg::*;
#(
   parameter int unsigned P_CYC_US = `SSG_CLK_MHZ,
   parameter int unsigned P_SM_DLY_US = `SSG_T_SM_DLY_US,
   parameter int unsigned P_WAKE_LONG_US = `SSG_T_WAKE_LONG_US,
   parameter int unsigned P_WAKE_SHORT_US = `SSG_T_WAKE_SHORT_US,
   parameter int unsigned P_RST_US = `SSG_T_RST_US,
   parameter int unsigned P_RST_EXTERNAL_SHIP_SWITCH_US = `SSG_T_RST_EXTERNAL_SHIP_SWITCH_US,
   parameter int unsigned P_WEAK_RETRY_US = `SSG_T_WEAK_RETRY_US,
   parameter int unsigned P_UV_OFF_US = `SSG_T_UV_OFF_US,
   parameter int unsigned P_INT_US = `SSG_T_INT_US
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog side
   input wire ssg_cmp_s cmp_i,
   input wire logic wake_button_n,
   input wire logic sw_cycle_i,
   output ssg_drv_s drv_o,
   output logic int_n
);

   // synchronised comparators and button
   ssg_cmp_s cmp_m_r;
   ssg_cmp_s s;
   logic btn_m_r;
   logic btn_n_r;
   // registers
   logic [`SSG_CTRL_W-1:0] ctrl_r;
   logic [`SSG_NEV-1:0] mask_r;
   logic [`SSG_NEV-1:0] stat_r;
   logic [`SSG_NEV-1:0] flag_r;
   logic [`SSG_NEV-1:0] stat_nxt;
   logic [`SSG_NEV-1:0] rise;
   logic ack_r;
   logic [31:0] dat_r;
   // state
   ssg_mode_e mode_r;
   ssg_drv_s drv_r;
   ssg_drv_s drv_nxt;
   logic [15:0] div_r;
   logic tick;
   logic [31:0] tmr_r;
   logic [31:0] btn_cnt_r;
   logic [31:0] weak_tmr_r;
   logic [31:0] uv_tmr_r;
   logic [31:0] int_tmr_r;
   logic int_n_r;
   logic weak_r;
   logic batovp_r;
   logic rsovp_r;
   logic adp_d_r;
   logic adp_rise;
   logic adp_fall;
   logic acc;
   logic wr;
   logic rd;
   logic wr_ctrl;
   logic reg_rst;
   logic wake_ev;
   logic prst_ev;
   logic prst_done;
   logic arm_done;
   logic ship_exit;
   logic uv_blk;
   ssg_ctl_e wr_mode;

   // true when a tick counter has just reached its limit
   function automatic logic hit(input logic [31:0] cnt, input int unsigned lim);
      hit = (cnt == 32'(lim));
   endfunction

   // two-flop synchroniser, first stage feeds only the second
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cmp_m_r <= '0;
         s <= '0;
         btn_m_r <= 1'b1;
         btn_n_r <= 1'b1;
      end else begin
         cmp_m_r <= cmp_i;
         s <= cmp_m_r;
         btn_m_r <= wake_button_n;
         btn_n_r <= btn_m_r;
      end
   end

   // microsecond tick; in ship mode only the flag slows the core clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_r <= '0;
      end else if (div_r == 16'(P_CYC_US - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end
   assign tick = (div_r == 16'(P_CYC_US - 1));

   // bus decode; a request is served in the cycle it is first seen
   assign acc = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr = acc && wb_we_i && wb_sel_i[0];
   assign rd = acc && !wb_we_i;
   // shutdown disables the serial port: writes are acked but ignored
   assign wr_ctrl = wr && (wb_adr_i == `SSG_ADR_CTRL) && (mode_r != M_SHUT);
   assign reg_rst = wr_ctrl && wb_dat_i[`SSG_C_RRST];
   assign wr_mode = ssg_ctl_e'(wb_dat_i[`SSG_C_MODE]);
   assign adp_rise = s.adapter_present && !adp_d_r;
   assign adp_fall = !s.adapter_present && adp_d_r;

   // button hold timer in microseconds, saturating at the reset hold
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         btn_cnt_r <= '0;
      end else if (btn_n_r) begin
         btn_cnt_r <= '0;
      end else if (tick && !hit(btn_cnt_r, P_RST_US)) begin
         btn_cnt_r <= btn_cnt_r + 32'h0000_0001;
      end
   end
   // one-cycle events on reaching a hold time
   assign wake_ev = tick && !btn_n_r && (ctrl_r[`SSG_C_WAKE] ?
      hit(btn_cnt_r + 32'h0000_0001, P_WAKE_SHORT_US) :
      hit(btn_cnt_r + 32'h0000_0001, P_WAKE_LONG_US));
   assign prst_ev = tick && !btn_n_r && hit(btn_cnt_r + 32'h0000_0001, P_RST_US);

   assign arm_done = !ctrl_r[`SSG_C_DLY] || hit(tmr_r, P_SM_DLY_US);
   assign prst_done = (mode_r == M_PRST) && hit(tmr_r, P_RST_EXTERNAL_SHIP_SWITCH_US);
   assign ship_exit = (mode_r == M_SHIP) && (adp_rise || wake_ev);

   // control register with hardware forcing of the mode field
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `SSG_CTRL_RST;
      end else begin
         if (reg_rst) begin
            ctrl_r <= `SSG_CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_r <= wb_dat_i[`SSG_CTRL_W-1:0];
            ctrl_r[`SSG_C_RRST] <= 1'b0;
            if (s.bus_high && (wr_mode == CTL_SHUT || wr_mode == CTL_SHIP)) begin
               ctrl_r[`SSG_C_MODE] <= CTL_IDLE;
            end
         end
         if (s.in_ocp && ctrl_r[`SSG_C_IOC]) begin
            ctrl_r[`SSG_C_HIZ] <= 1'b1; // set wins over host clear
            ctrl_r[`SSG_C_DIS] <= 1'b1;
         end else if (adp_fall) begin
            ctrl_r[`SSG_C_HIZ] <= 1'b0;
            ctrl_r[`SSG_C_DIS] <= 1'b0;
         end
         if (ship_exit) begin
            ctrl_r[`SSG_C_MODE] <= CTL_IDLE;
         end
         if ((mode_r == M_SHUT) && adp_rise) begin
            ctrl_r[`SSG_C_MODE] <= CTL_IDLE;
         end
         if (prst_done) begin
            ctrl_r[`SSG_C_MODE] <= CTL_IDLE;
         end
      end
   end

   // mode state machine and its tick timer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= M_IDLE;
         tmr_r <= '0;
      end else begin
         if (tick) begin
            tmr_r <= tmr_r + 32'h0000_0001;
         end
         case (mode_r)
            M_IDLE: begin
               tmr_r <= '0;
               if (prst_ev) begin
                  mode_r <= M_PRST;
               end else if (ctrl_r[`SSG_C_MODE] != CTL_IDLE) begin
                  mode_r <= M_ARM;
               end
            end
            M_ARM: begin
               if (ctrl_r[`SSG_C_MODE] == CTL_IDLE) begin
                  mode_r <= M_IDLE;
               end else if (arm_done) begin
                  tmr_r <= '0;
                  case (ctrl_r[`SSG_C_MODE])
                     CTL_SHUT: mode_r <= M_SHUT;
                     CTL_SHIP: mode_r <= M_SHIP;
                     default: mode_r <= M_PRST;
                  endcase
               end
            end
            M_SHIP: begin
               if (ship_exit || ctrl_r[`SSG_C_MODE] == CTL_IDLE) begin
                  mode_r <= M_IDLE;
               end
            end
            M_SHUT: begin
               if (adp_rise) begin
                  mode_r <= M_IDLE;
               end
            end
            M_PRST: begin
               if (prst_done) begin
                  mode_r <= M_IDLE;
               end
            end
            default: mode_r <= M_IDLE;
         endcase
      end
   end

   // fault hysteresis and weak source retest
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         adp_d_r <= 1'b0;
         batovp_r <= 1'b0;
         rsovp_r <= 1'b0;
         weak_r <= 1'b0;
         weak_tmr_r <= '0;
      end else begin
         adp_d_r <= s.adapter_present;
         if (s.bat_above_104) begin
            batovp_r <= 1'b1;
         end else if (!s.bat_above_102) begin
            batovp_r <= 1'b0;
         end
         // stop only on a switching cycle boundary
         if (sw_cycle_i && s.rs_ovp_rise && ctrl_r[`SSG_C_RS]) begin
            rsovp_r <= 1'b1;
         end else if (!s.rs_ovp_fall) begin
            rsovp_r <= 1'b0;
         end
         if (!s.adapter_present) begin
            weak_r <= 1'b0;
            weak_tmr_r <= '0;
         end else if (adp_rise || (weak_r && tick && hit(weak_tmr_r, P_WEAK_RETRY_US))) begin
            weak_r <= s.weak_fail;
            weak_tmr_r <= '0;
         end else if (weak_r && tick) begin
            weak_tmr_r <= weak_tmr_r + 32'h0000_0001;
         end
      end
   end

   // reverse source undervoltage off time
   assign uv_blk = (uv_tmr_r != 32'h0000_0000);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         uv_tmr_r <= '0;
      end else if (!uv_blk && ctrl_r[`SSG_C_RS] && drv_r.conv_en && s.rs_uv) begin
         uv_tmr_r <= 32'(P_UV_OFF_US);
      end else if (uv_blk && tick) begin
         uv_tmr_r <= uv_tmr_r - 32'h0000_0001;
      end
   end

   // output drive decisions
   always_comb begin
      drv_nxt.ext_ship_on = !(mode_r inside {M_SHIP, M_SHUT, M_PRST})
         && !(s.bat_ocp && ctrl_r[`SSG_C_FIT] && ctrl_r[`SSG_C_BOC]);
      drv_nxt.batt_sw_on = !(mode_r inside {M_SHIP, M_SHUT});
      drv_nxt.in_sw1_on = !s.vac1_ovp && !ctrl_r[`SSG_C_DIS] && (mode_r != M_SHUT);
      drv_nxt.in_sw2_on = !s.vac2_ovp && !ctrl_r[`SSG_C_DIS] && (mode_r != M_SHUT);
      drv_nxt.in_sel = s.vac1_ovp && !s.vac2_ovp;
      drv_nxt.input_hiz = ((mode_r == M_PRST) && s.bus_high) || ctrl_r[`SSG_C_HIZ];
      drv_nxt.sys_sink = (mode_r == M_PRST);
      drv_nxt.cur_limit = s.sys_short;
      drv_nxt.slow_clk = (mode_r == M_SHIP);
      drv_nxt.serial_off = (mode_r == M_SHUT);
      // any protective stop wins over regulation
      drv_nxt.conv_en = !(drv_nxt.input_hiz || ctrl_r[`SSG_C_DIS] || s.bus_ovp || weak_r
         || s.sys_ovp || batovp_r || (mode_r inside {M_SHIP, M_SHUT})
         || (ctrl_r[`SSG_C_RS] && (rsovp_r || uv_blk)));
   end

   // status vector, flags and masked notification
   always_comb begin
      stat_nxt = '0;
      stat_nxt[`SSG_E_VAC1] = s.vac1_ovp;
      stat_nxt[`SSG_E_VAC2] = s.vac2_ovp;
      stat_nxt[`SSG_E_BOVP] = s.bus_ovp;
      stat_nxt[`SSG_E_WEAK] = weak_r;
      stat_nxt[`SSG_E_SOVP] = s.sys_ovp;
      stat_nxt[`SSG_E_SSHT] = s.sys_short;
      stat_nxt[`SSG_E_BATOVP] = batovp_r;
      stat_nxt[`SSG_E_BOCP] = s.bat_ocp;
      stat_nxt[`SSG_E_IOCP] = s.in_ocp;
      stat_nxt[`SSG_E_RSOVP] = rsovp_r;
      stat_nxt[`SSG_E_RSUV] = uv_blk;
   end
   assign rise = stat_nxt & ~stat_r;

   // sticky flags; a new edge beats a read in the same cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stat_r <= '0;
         flag_r <= '0;
      end else begin
         stat_r <= stat_nxt;
         if (rd && wb_adr_i == `SSG_ADR_FLAG) begin
            flag_r <= rise;
         end else begin
            flag_r <= flag_r | rise;
         end
      end
   end

   // notification pulse, restarted by every unmasked edge
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         int_tmr_r <= '0;
         int_n_r <= 1'b1;
      end else if (|(rise & ~mask_r)) begin
         int_tmr_r <= '0;
         int_n_r <= 1'b0;
      end else if (!int_n_r && tick) begin
         int_tmr_r <= int_tmr_r + 32'h0000_0001;
         if (hit(int_tmr_r + 32'h0000_0001, P_INT_US)) begin
            int_n_r <= 1'b1;
         end
      end
   end

   // mask register, weak source bit is the good power mask
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= `SSG_MASK_RST;
      end else if (reg_rst) begin
         mask_r <= `SSG_MASK_RST;
      end else if (wr && wb_adr_i == `SSG_ADR_MASK && mode_r != M_SHUT) begin
         mask_r <= wb_dat_i[`SSG_NEV-1:0];
      end
   end

   // bus answer one cycle after the request, unmapped reads give zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= acc;
         dat_r <= '0;
         if (rd) begin
            case (wb_adr_i)
               `SSG_ADR_CTRL: dat_r <= 32'(ctrl_r);
               `SSG_ADR_MASK: dat_r <= 32'(mask_r);
               `SSG_ADR_STAT: dat_r <= 32'(stat_r);
               `SSG_ADR_FLAG: dat_r <= 32'(flag_r);
               `SSG_ADR_OUT: dat_r <= {18'h0_0000, mode_r, drv_r};
               default: dat_r <= '0;
            endcase
         end
      end
   end

   // registered pins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         drv_r <= '0;
      end else begin
         drv_r <= drv_nxt;
      end
   end
   assign drv_o = drv_r;
   assign int_n = int_n_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_busy_write;
      wr_ctrl && s.bus_high && (wr_mode inside {CTL_SHUT, CTL_SHIP}) && !reg_rst;
   endsequence
   sequence s_prst_hold;
      (mode_r == M_PRST) [*2];
   endsequence
   sequence s_unmasked_edge;
      |(rise & ~mask_r);
   endsequence

   property p_busy_reject;
      s_busy_write |=> (ctrl_r[`SSG_C_MODE] == CTL_IDLE);
   endproperty
   a_busy_reject: assert property (p_busy_reject) else $error("busy mode write kept");

   property p_ship_off;
      (mode_r == M_SHIP) |=> !drv_r.ext_ship_on && !drv_r.batt_sw_on && drv_r.slow_clk;
   endproperty
   a_ship_off: assert property (p_ship_off) else $error("ship mode switches on");

   property p_arm_now;
      (mode_r == M_ARM) && !ctrl_r[`SSG_C_DLY] && (ctrl_r[`SSG_C_MODE] != CTL_IDLE)
         |=> (mode_r != M_ARM);
   endproperty
   a_arm_now: assert property (p_arm_now) else $error("undelayed entry stalled");

   property p_prst_sink;
      s_prst_hold |-> drv_r.sys_sink && !drv_r.ext_ship_on;
   endproperty
   a_prst_sink: assert property (p_prst_sink) else $error("reset without sink");

   property p_prst_end;
      $fell(mode_r == M_PRST) |-> (ctrl_r[`SSG_C_MODE] == CTL_IDLE);
   endproperty
   a_prst_end: assert property (p_prst_end) else $error("mode not back to idle");

   property p_int_pulse;
      s_unmasked_edge |=> !int_n_r ##1 !int_n_r;
   endproperty
   a_int_pulse: assert property (p_int_pulse) else $error("no notify pulse");

   property p_flag_set;
      |rise |=> |(flag_r & $past(rise));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not latched");

   property p_ocp_act;
      s.in_ocp && ctrl_r[`SSG_C_IOC] |=> ctrl_r[`SSG_C_HIZ] && ctrl_r[`SSG_C_DIS]
         ##1 !drv_r.conv_en;
   endproperty
   a_ocp_act: assert property (p_ocp_act) else $error("overcurrent not acted");

   property p_bus_ovp;
      s.bus_ovp |=> !drv_r.conv_en;
   endproperty
   a_bus_ovp: assert property (p_bus_ovp) else $error("converter runs in bus ovp");

endmodule

// >>> test/ssg_analog_model.sv
// far side model: comparators, wake button and switching-cycle strobe
`timescale 1ns/1ps
module ssg_analog_model
   import ssg_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // bench requests
   input wire ssg_cmp_s want_i,
   input wire logic press_i,
   // towards the block
   output ssg_cmp_s cmp_o,
   output logic wake_button_n,
   output logic sw_cycle_o
);
   logic [1:0] cnt_r = 2'h0;
   // falling comparator can never sit below the rising one
   always_comb begin
      cmp_o = want_i;
      cmp_o.rs_ovp_fall = want_i.rs_ovp_fall | want_i.rs_ovp_rise;
   end
   // pin is pulled up, so a released button reads high
   assign wake_button_n = ~press_i;
   // converter boundary every fourth clock, free running like the real stage
   always_ff @(posedge ref_clk) begin
      cnt_r <= cnt_r + 2'h1;
   end
   assign sw_cycle_o = (cnt_r == 2'h3);
endmodule

// >>> test/ssg_top_bench.sv
// bench for the ship switch mode and fault guard
`timescale 1ns/1ps
`include "ssg_consts.svh"
module ssg_top_bench
   import ssg_pkg::*;
;
   logic ref_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, press = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat, q;
   logic ack, int_n, wbn, swc;
   ssg_cmp_s want = '0, cmp;
   ssg_drv_s drv;
   int fail_count = 0, checks = 0;
   // short timings keep the run small
   ssg_top #(.P_CYC_US(4), .P_SM_DLY_US(20), .P_WAKE_LONG_US(10), .P_WAKE_SHORT_US(3),
      .P_RST_US(40), .P_RST_EXTERNAL_SHIP_SWITCH_US(15), .P_WEAK_RETRY_US(30), .P_UV_OFF_US(12),
      .P_INT_US(4)) ssg_top_inst (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_i(cmp), .wake_button_n(wbn),
      .sw_cycle_i(swc), .drv_o(drv), .int_n(int_n));
   ssg_analog_model ssg_analog_model_inst (.ref_clk(ref_clk), .want_i(want),
      .press_i(press), .cmp_o(cmp), .wake_button_n(wbn), .sw_cycle_o(swc));
   // 250 MHz clock
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_pin(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   // one classic cycle; old ack is seen right after the edge, before it updates
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      if (n >= 64) fail_count++;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard, far beyond the roughly 500 cycles the tests need
   initial begin
      tick(30000);
      fail_count++;
      print_verdict();
   end
   initial begin
      tick(12);
      rstn <= 1'b1;
      tick(2);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("ctrl", 32'h0000_0000, q);
      bus(0, 8'h20, 0);
      chk_reg("unmapped", 32'h0000_0000, q);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      $display("test reset done");
      want.bus_high <= 1'b1;
      tick(4);
      bus(1, `SSG_ADR_CTRL, 2);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("field", 32'h0000_0000, q & 32'h0000_0003);
      bus(1, `SSG_ADR_CTRL, 1);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("field", 32'h0000_0000, q & 32'h0000_0003);
      want.bus_high <= 1'b0;
      tick(4);
      $display("test refused done");
      bus(1, `SSG_ADR_CTRL, 2);
      tick(6);
      chk_pin("ship_on", 1'b0, drv.ext_ship_on);
      chk_pin("batt_on", 1'b0, drv.batt_sw_on);
      chk_pin("slow_clk", 1'b1, drv.slow_clk);
      bus(1, `SSG_ADR_CTRL, 0);
      tick(6);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      chk_pin("batt_on", 1'b1, drv.batt_sw_on);
      bus(1, `SSG_ADR_CTRL, 32'h0000_000A);
      tick(6);
      press <= 1'b1;
      tick(30);
      press <= 1'b0;
      tick(6);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("field", 32'h0000_0000, q & 32'h0000_0003);
      $display("test ship done");
      bus(1, `SSG_ADR_CTRL, 3);
      tick(10);
      chk_pin("ship_on", 1'b0, drv.ext_ship_on);
      chk_pin("sink", 1'b1, drv.sys_sink);
      chk_pin("hiz", 1'b0, drv.input_hiz);
      tick(80);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      chk_pin("sink", 1'b0, drv.sys_sink);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("field", 32'h0000_0000, q & 32'h0000_0003);
      $display("test power reset done");
      want.bus_ovp <= 1'b1;
      tick(8);
      chk_pin("int_n", 1'b0, int_n);
      chk_pin("conv_en", 1'b0, drv.conv_en);
      chk_pin("batt_on", 1'b1, drv.batt_sw_on);
      bus(0, `SSG_ADR_STAT, 0);
      chk_reg("stat", 32'h0000_0004, q & 32'h0000_0004);
      tick(40);
      chk_pin("int_n", 1'b1, int_n);
      want.bus_ovp <= 1'b0;
      bus(0, `SSG_ADR_FLAG, 0);
      chk_reg("flag", 32'h0000_0004, q & 32'h0000_0004);
      bus(0, `SSG_ADR_FLAG, 0);
      chk_reg("flag", 32'h0000_0000, q & 32'h0000_0004);
      bus(1, `SSG_ADR_MASK, 4);
      want.bus_ovp <= 1'b1;
      tick(8);
      chk_pin("int_n", 1'b1, int_n);
      bus(0, `SSG_ADR_FLAG, 0);
      chk_reg("flag", 32'h0000_0004, q & 32'h0000_0004);
      want.bus_ovp <= 1'b0;
      bus(1, `SSG_ADR_MASK, 0);
      $display("test events done");
      bus(1, `SSG_ADR_CTRL, 32'h0000_0030);
      want.bat_ocp <= 1'b1;
      tick(8);
      chk_pin("ship_on", 1'b0, drv.ext_ship_on);
      want.bat_ocp <= 1'b0;
      bus(0, `SSG_ADR_FLAG, 0);
      bus(1, `SSG_ADR_CTRL, 32'h0000_0020);
      want.bat_ocp <= 1'b1;
      tick(8);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      bus(0, `SSG_ADR_FLAG, 0);
      chk_reg("flag", 32'h0000_0080, q & 32'h0000_0080);
      want.bat_ocp <= 1'b0;
      $display("test battery current done");
      bus(1, `SSG_ADR_CTRL, 32'h0000_0005);
      tick(20);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      tick(80);
      chk_pin("ship_on", 1'b0, drv.ext_ship_on);
      chk_pin("serial_off", 1'b1, drv.serial_off);
      bus(1, `SSG_ADR_CTRL, 0);
      tick(6);
      chk_pin("serial_off", 1'b1, drv.serial_off);
      want.adapter_present <= 1'b1;
      tick(8);
      chk_pin("ship_on", 1'b1, drv.ext_ship_on);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("field", 32'h0000_0000, q & 32'h0000_0003);
      $display("test shutdown done");
      // input, rail and battery faults with the adapter still present
      want.vac1_ovp <= 1'b1;
      tick(8);
      chk_pin("in_sw1", 1'b0, drv.in_sw1_on);
      chk_pin("in_sel", 1'b1, drv.in_sel);
      want.vac1_ovp <= 1'b0;
      tick(8);
      chk_pin("in_sw1", 1'b1, drv.in_sw1_on);
      want.sys_short <= 1'b1;
      want.sys_ovp <= 1'b1;
      tick(8);
      chk_pin("cur_limit", 1'b1, drv.cur_limit);
      chk_pin("conv_en", 1'b0, drv.conv_en);
      want.sys_short <= 1'b0;
      want.sys_ovp <= 1'b0;
      tick(8);
      chk_pin("conv_en", 1'b1, drv.conv_en);
      want.bat_above_104 <= 1'b1;
      want.bat_above_102 <= 1'b1;
      tick(8);
      want.bat_above_104 <= 1'b0;
      tick(8);
      chk_pin("conv_en", 1'b0, drv.conv_en);
      want.bat_above_102 <= 1'b0;
      tick(8);
      chk_pin("conv_en", 1'b1, drv.conv_en);
      bus(1, `SSG_ADR_CTRL, 32'h0000_0040);
      want.in_ocp <= 1'b1;
      tick(8);
      want.in_ocp <= 1'b0;
      chk_pin("conv_en", 1'b0, drv.conv_en);
      chk_pin("in_sw2", 1'b0, drv.in_sw2_on);
      bus(0, `SSG_ADR_CTRL, 0);
      chk_reg("ocp bits", 32'h0000_0180, q & 32'h0000_0180);
      bus(1, `SSG_ADR_CTRL, 0);
      tick(8);
      chk_pin("conv_en", 1'b1, drv.conv_en);
      $display("test faults done");
      print_verdict();
   end
endmodule
